// ===== hdl/battery_dcdc_pwm_controller.sv
// buck-boost battery converter pwm controller with apb register slave
`timescale 1ns/1ps
`include "dcdc_defines.svh"
module battery_dcdc_pwm_controller import dcdc_pkg::*; #(
   parameter logic SAME_POLARITY = 1'b0,
   parameter int CAL_CYCLES = `CAL_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire apb_req_type apb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire line_state_type line_i,
   input wire logic [5:0] battery_sense_i,
   input wire logic input_monitor_high_i,
   input wire logic input_monitor_low_i,
   output logic primary_switch_drive_o,
   output logic secondary_switch_drive_o
);
   // ----------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------
   logic [7:0] power_down_q, power_down_d;
   logic [7:0] headroom_feed_q, headroom_feed_d;
   logic [7:0] high_batt_q, high_batt_d;
   logic [7:0] low_batt_q, low_batt_d;
   logic [7:0] period_q, period_d;
   logic [4:0] min_off_q, min_off_d;
   logic [7:0] enhance_q, enhance_d;
   logic [3:0] headroom_q, headroom_d;
   logic [7:0] ind_addr_q, ind_addr_d;
   logic [7:0] ind_data_q, ind_data_d;

   logic [7:0] reg_idx;
   logic idx_ok;
   logic wr_en;
   logic mapped;
   logic cal_start;
   logic [7:0] rd_byte;

   // ----------------------------------------------------------------------
   // calibration, tick, loop state
   // ----------------------------------------------------------------------
   cal_state_type cal_st_q, cal_st_d;
   logic [$clog2(CAL_CYCLES+1)-1:0] cal_cnt_q, cal_cnt_d;
   logic [1:0] mon_base_q, mon_base_d;
   logic [14:0] acc_q, acc_d;
   logic [15:0] acc_sum;
   logic tick;
   logic [7:0] width_q, width_d;
   logic signed [3:0] vote_q, vote_d;
   logic [2:0] vote_cnt_q, vote_cnt_d;

   logic run;
   logic overload;
   logic period_start;
   logic drive;
   logic [6:0] headroom_code;
   logic [6:0] target;
   logic [7:0] target_sum;
   logic below;
   logic [6:0] err;
   logic [8:0] max_width;
   logic [8:0] step;

   // ----------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------
   // word aligned only; upper address bits must be clear
   assign reg_idx = apb_i.paddr[9:2];
   assign idx_ok = (apb_i.paddr[31:10] == '0) && (apb_i.paddr[1:0] == 2'b00);
   assign pready_o = 1'b1;

   always_comb begin
      case (reg_idx)
         `IDX_IND_DATA_LO, `IDX_IND_DATA_HI, `IDX_IND_ADDR, `IDX_IND_STATUS,
         `IDX_POWER_DOWN, `IDX_HEADROOM_FEED, `IDX_HIGH_BATT, `IDX_LOW_BATT,
         `IDX_PWM_PERIOD, `IDX_SW_DELAY, `IDX_PULSE_WIDTH,
         `IDX_ENHANCE: mapped = idx_ok;
         default: mapped = 1'b0;
      endcase
   end

   assign pslverr_o = apb_i.psel && apb_i.penable && !mapped;
   assign wr_en = apb_i.psel && apb_i.penable && apb_i.pwrite && mapped;

   // read mux; narrow registers sit in the low byte
   always_comb begin
      case (reg_idx)
         // R18: indirect window
         `IDX_IND_DATA_LO: rd_byte = ind_data_q;
         `IDX_IND_ADDR: rd_byte = ind_addr_q;
         `IDX_POWER_DOWN: rd_byte = power_down_q;
         `IDX_HEADROOM_FEED: rd_byte = headroom_feed_q;
         `IDX_HIGH_BATT: rd_byte = high_batt_q;
         `IDX_LOW_BATT: rd_byte = low_batt_q;
         `IDX_PWM_PERIOD: rd_byte = period_q;
         // R20: variant flag
         `IDX_SW_DELAY: rd_byte = {cal_st_q == CAL_RUN, 1'b0, SAME_POLARITY, min_off_q};
         // R5: width readback
         `IDX_PULSE_WIDTH: rd_byte = width_q;
         `IDX_ENHANCE: rd_byte = enhance_q;
         default: rd_byte = 8'h00;
      endcase
      prdata_o = (apb_i.psel && apb_i.penable && mapped && !apb_i.pwrite) ?
                 {24'h000000, rd_byte} : 32'h00000000;
   end

   // ----------------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------------
   always_comb begin
      power_down_d = power_down_q;
      headroom_feed_d = headroom_feed_q;
      high_batt_d = high_batt_q;
      low_batt_d = low_batt_q;
      period_d = period_q;
      min_off_d = min_off_q;
      enhance_d = enhance_q;
      headroom_d = headroom_q;
      ind_addr_d = ind_addr_q;
      ind_data_d = ind_data_q;
      cal_start = 1'b0;
      if (wr_en) begin
         case (reg_idx)
            `IDX_POWER_DOWN: power_down_d = apb_i.pwdata[7:0];
            `IDX_HEADROOM_FEED: headroom_feed_d = apb_i.pwdata[7:0];
            `IDX_HIGH_BATT: high_batt_d = {2'b00, apb_i.pwdata[5:0]};
            `IDX_LOW_BATT: low_batt_d = {2'b00, apb_i.pwdata[5:0]};
            // R4: period field
            `IDX_PWM_PERIOD: period_d = apb_i.pwdata[7:0];
            `IDX_SW_DELAY: begin
               min_off_d = apb_i.pwdata[4:0];
               cal_start = apb_i.pwdata[`BIT_CAL];
            end
            `IDX_ENHANCE: enhance_d = apb_i.pwdata[7:0];
            // R18: address write fetches the indirect word
            `IDX_IND_ADDR: begin
               ind_addr_d = apb_i.pwdata[7:0];
               ind_data_d = (apb_i.pwdata[7:0] == `IND_IDX_HEADROOM) ?
                            {4'h0, headroom_q} : 8'h00;
            end
            // R18: data write stores to the addressed indirect word
            `IDX_IND_DATA_LO: begin
               ind_data_d = apb_i.pwdata[7:0];
               if (ind_addr_q == `IND_IDX_HEADROOM) begin
                  headroom_d = apb_i.pwdata[3:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // R19: converter comes up powered off
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         power_down_q <= `RST_POWER_DOWN;
         headroom_feed_q <= `RST_HEADROOM_FEED;
         high_batt_q <= `RST_HIGH_BATT;
         low_batt_q <= `RST_LOW_BATT;
         period_q <= `RST_PWM_PERIOD;
         min_off_q <= `RST_MIN_OFF;
         enhance_q <= `RST_ENHANCE;
         headroom_q <= `RST_HEADROOM;
         ind_addr_q <= 8'h00;
         ind_data_q <= 8'h00;
      end else begin
         power_down_q <= power_down_d;
         headroom_feed_q <= headroom_feed_d;
         high_batt_q <= high_batt_d;
         low_batt_q <= low_batt_d;
         period_q <= period_d;
         min_off_q <= min_off_d;
         enhance_q <= enhance_d;
         headroom_q <= headroom_d;
         ind_addr_q <= ind_addr_d;
         ind_data_q <= ind_data_d;
      end
   end

   // ----------------------------------------------------------------------
   // monitor calibration
   // ----------------------------------------------------------------------
   // the idle level of each monitor is learnt so that only a departure
   // from it counts as overload; switching is held off meanwhile
   always_comb begin
      cal_st_d = cal_st_q;
      cal_cnt_d = cal_cnt_q;
      mon_base_d = mon_base_q;
      case (cal_st_q)
         CAL_IDLE: begin
            // R7: calibration started by software
            if (cal_start) begin
               cal_st_d = CAL_RUN;
               cal_cnt_d = '0;
            end
         end
         CAL_RUN: begin
            mon_base_d = {input_monitor_high_i, input_monitor_low_i};
            if (cal_cnt_q == ($bits(cal_cnt_q))'(CAL_CYCLES - 1)) begin
               cal_st_d = CAL_IDLE;
            end else begin
               cal_cnt_d = cal_cnt_q + 1'b1;
            end
         end
         default: cal_st_d = CAL_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cal_st_q <= CAL_IDLE;
         cal_cnt_q <= '0;
         mon_base_q <= 2'b00;
      end else begin
         cal_st_q <= cal_st_d;
         cal_cnt_q <= cal_cnt_d;
         mon_base_q <= mon_base_d;
      end
   end

   // R3: any monitor away from its idle level is overload
   assign overload = ({input_monitor_high_i, input_monitor_low_i} != mon_base_q);

   // ----------------------------------------------------------------------
   // 16.384 MHz tick from the 20 MHz clock
   // ----------------------------------------------------------------------
   // fractional accumulator, sum one bit wider since it passes 15 bits
   assign acc_sum = {1'b0, acc_q} + 16'(`TICK_KHZ);
   always_comb begin
      tick = acc_sum >= 16'(`CLK_KHZ);
      acc_d = tick ? 15'(acc_sum - 16'(`CLK_KHZ)) : acc_sum[14:0];
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         acc_q <= 15'h0000;
      end else begin
         acc_q <= acc_d;
      end
   end

   // ----------------------------------------------------------------------
   // battery target
   // ----------------------------------------------------------------------
   // R12: headroom in 1.5 V codes, clamped to the selected range
   always_comb begin
      headroom_code = {3'b000, headroom_q};
      if (headroom_feed_q[`BIT_RANGE_SEL]) begin
         if (headroom_code > `HEADROOM_MAX_WIDE) headroom_code = `HEADROOM_MAX_WIDE;
      end else begin
         if (headroom_code > `HEADROOM_MAX_NARROW) headroom_code = `HEADROOM_MAX_NARROW;
      end
   end

   assign target_sum = {2'b00, line_i.common_mode} + {2'b00, line_i.open_circuit} +
                       {1'b0, headroom_code};
   always_comb begin
      if (line_i.ringing) begin
         // R13: ringing burst regulates to high setting
         target = {1'b0, high_batt_q[5:0]};
      end else if (line_i.const_current) begin
         // R11: follow bit picks tracking or low floor
         target = {1'b0, line_i.current_track};
         if (!headroom_feed_q[`BIT_LOOP_FOLLOW] && target < {1'b0, low_batt_q[5:0]}) begin
            target = {1'b0, low_batt_q[5:0]};
         end
      end else begin
         // R10: R15: active target, also after ringing ends
         target = (target_sum > {1'b0, `TARGET_MAX}) ? `TARGET_MAX : target_sum[6:0];
      end
      if (target > `TARGET_MAX) target = `TARGET_MAX;
   end

   // R2: battery magnitude compared with the target reference
   assign below = {1'b0, battery_sense_i} < target;
   assign err = below ? 7'(target - {1'b0, battery_sense_i}) :
                        7'({1'b0, battery_sense_i} - target);

   // ----------------------------------------------------------------------
   // pulse width loop, updated once per period, or every eighth period with the loop filter
   // ----------------------------------------------------------------------
   // R1: power-off bit gates the converter; calibration also holds it off
   assign run = !power_down_q[`BIT_POWER_OFF] && (cal_st_q == CAL_IDLE);

   always_comb begin
      // R6: width capped so off time is field plus four ticks
      if ({1'b0, period_q} > 9'({4'h0, min_off_q} + `MIN_OFF_EXTRA)) begin
         max_width = 9'({1'b0, period_q} - {4'h0, min_off_q} - `MIN_OFF_EXTRA);
      end else begin
         max_width = 9'h000;
      end
      // R16: large error takes a coarser step
      step = (enhance_q[`BIT_FAST_SETTLE] && err > `FAST_ERR_THRESH) ? `FAST_STEP : 9'h001;
      width_d = width_q;
      vote_d = vote_q;
      vote_cnt_d = vote_cnt_q;
      if (!run) begin
         width_d = 8'h00;
         vote_d = 4'sh0;
         vote_cnt_d = 3'h0;
      end else if (period_start) begin
         if (enhance_q[`BIT_LOOP_FILTER]) begin
            // R17: decisions of seven periods voted, width stepped every eighth period, rejects audio band
            vote_d = below ? vote_q + 4'sh1 : vote_q - 4'sh1;
            vote_cnt_d = vote_cnt_q + 3'h1;
            if (vote_cnt_q == `FILTER_PERIODS) begin
               vote_d = 4'sh0;
               if (vote_q > 4'sh0) begin
                  width_d = 8'(({1'b0, width_q} + step > max_width) ? max_width :
                                {1'b0, width_q} + step);
               end else if (vote_q < 4'sh0) begin
                  width_d = 8'(({1'b0, width_q} > step) ? {1'b0, width_q} - step : 9'h000);
               end
            end
         end else if (below) begin
            width_d = 8'(({1'b0, width_q} + step > max_width) ? max_width :
                          {1'b0, width_q} + step);
         end else if (err != 7'h00) begin
            width_d = 8'(({1'b0, width_q} > step) ? {1'b0, width_q} - step : 9'h000);
         end
      end
      // R6: a shorter period or longer off time takes effect at once
      if ({1'b0, width_d} > max_width) width_d = max_width[7:0];
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         width_q <= 8'h00;
         vote_q <= 4'sh0;
         vote_cnt_q <= 3'h0;
      end else begin
         width_q <= width_d;
         vote_q <= vote_d;
         vote_cnt_q <= vote_cnt_d;
      end
   end

   // ----------------------------------------------------------------------
   // switch drive
   // ----------------------------------------------------------------------
   // R5: drive asserted for the computed width each period
   dcdc_pulse_timer #(
      .WIDTH(8)
   ) u_timer (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .tick_i(tick),
      .run_i(run),
      .kill_i(overload),
      .period_i(period_q),
      .width_i(width_q),
      .drive_o(drive),
      .period_start_o(period_start)
   );

   // both outputs low while off, whatever the variant
   always_comb begin
      if (SAME_POLARITY) begin
         // R9: transformer variant, primary unused
         primary_switch_drive_o = 1'b0;
         secondary_switch_drive_o = drive;
      end else begin
         // R8: standard variant, opposite polarity
         primary_switch_drive_o = drive;
         secondary_switch_drive_o = run && !drive;
      end
   end
endmodule

// ===== pkg/dcdc_defines.svh
// offsets, fields, reset values and timing counts of the dc-dc pwm controller
// Function
// R1: power-off bit clear runs converter, set halts
// R2: compare battery sense against target reference
// R3: overload kills drive for rest of period
// R4: 8-bit period field, 61.035 ns per count
// R5: drive for computed width, width readable
// R6: minimum off time is field plus four
// R7: software calibrates monitors after power-on
// R8: standard variant: secondary opposite to primary
// R9: transformer variant: secondary same, primary unused
// R10: active target is common-mode plus open-circuit plus headroom
// R11: follow bit clear stops target at low
// R12: headroom in 1.5 V steps, two ranges
// R13: ringing regulates to high battery setting
// R14: high setting must exceed ringing amplitude
// R15: after ringing burst return to active target
// R16: fast-settle bit selects multi-threshold control
// R17: loop-filter bit inserts audio-band rejection
// R18: indirect registers only through direct 28-31
// R19: after reset converter off, drives low
// R20: read-only polarity flag reports variant
`ifndef DCDC_DEFINES_SVH
`define DCDC_DEFINES_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_IND_DATA_LO 8'd28
`define IDX_IND_DATA_HI 8'd29
`define IDX_IND_ADDR 8'd30
`define IDX_IND_STATUS 8'd31
`define IDX_POWER_DOWN 8'd14
`define IDX_HEADROOM_FEED 8'd66
`define IDX_HIGH_BATT 8'd74
`define IDX_LOW_BATT 8'd75
`define IDX_PWM_PERIOD 8'd92
`define IDX_SW_DELAY 8'd93
`define IDX_PULSE_WIDTH 8'd94
`define IDX_ENHANCE 8'd108
`define IND_IDX_HEADROOM 8'd41

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_POWER_OFF 4
`define BIT_RANGE_SEL 0
`define BIT_LOOP_FOLLOW 2
`define BIT_CAL 7
`define BIT_POLARITY 5
`define BIT_FAST_SETTLE 5
`define BIT_LOOP_FILTER 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_POWER_DOWN 8'h10
`define RST_HEADROOM_FEED 8'h04
`define RST_HIGH_BATT 8'h00
`define RST_LOW_BATT 8'h00
`define RST_PWM_PERIOD 8'hff
`define RST_MIN_OFF 5'h00
`define RST_ENHANCE 8'h00
`define RST_HEADROOM 4'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_KHZ 20000
`define TICK_KHZ 16384
`define MIN_OFF_EXTRA 9'd4
`define HEADROOM_MAX_NARROW 7'd6
`define HEADROOM_MAX_WIDE 7'd9
`define TARGET_MAX 7'd63
`define FAST_ERR_THRESH 7'd2
`define FAST_STEP 9'd4
`define FILTER_PERIODS 3'd7
`define CAL_TIME_NS 100000
`define CAL_CYCLES ((`CAL_TIME_NS * (`CLK_KHZ / 1000)) / 1000)

`endif

// ===== pkg/dcdc_pkg.sv
// types shared by the dc-dc pwm controller files
package dcdc_pkg;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   // line-feed state that steers the battery target, codes in 1.5 V steps
   typedef struct packed {
      logic ringing;
      logic const_current;
      logic [5:0] common_mode;
      logic [5:0] open_circuit;
      logic [5:0] current_track;
   } line_state_type;

   // calibration sequencer states
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b01,
      CAL_RUN = 2'b10
   } cal_state_type;

endpackage

// ===== hdl/dcdc_pulse_timer.sv
// pwm period counter and switch pulse generator on the 16.384 MHz tick
`timescale 1ns/1ps
module dcdc_pulse_timer #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic tick_i,
   input wire logic run_i,
   input wire logic kill_i,
   input wire logic [WIDTH-1:0] period_i,
   input wire logic [WIDTH-1:0] width_i,
   output logic drive_o,
   output logic period_start_o
);
   logic [WIDTH-1:0] cnt_q, cnt_d;
   logic killed_q, killed_d;
   logic drive_q, drive_d;
   logic wrap;

   // ----------------------------------------------------------------------
   // period count and drive
   // ----------------------------------------------------------------------
   // a zero period still counts one tick so the counter never stalls
   assign wrap = tick_i && (cnt_q >= period_i - WIDTH'(1) || period_i == '0);
   assign period_start_o = wrap;

   always_comb begin
      cnt_d = cnt_q;
      if (!run_i) begin
         cnt_d = '0;
      end else if (wrap) begin
         cnt_d = '0;
      end else if (tick_i) begin
         cnt_d = cnt_q + WIDTH'(1);
      end
      // R3: overload latch
      // a new overload wins over the period boundary clear
      killed_d = kill_i || (killed_q && !wrap);
      drive_d = run_i && !killed_d && (cnt_d < width_i);
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt_q <= '0;
         killed_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         killed_q <= killed_d;
         drive_q <= drive_d;
      end
   end

   assign drive_o = drive_q;
endmodule

// ===== verification/battery_dcdc_pwm_controller_sva.sv
// concurrent checks on the pins of the dc-dc pwm controller
`timescale 1ns/1ps
module battery_dcdc_pwm_controller_sva import dcdc_pkg::*; #(
   parameter logic SAME_POLARITY = 1'b0
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire apb_req_type apb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic input_monitor_high_i,
   input wire logic primary_switch_drive_o,
   input wire logic secondary_switch_drive_o
);
   // ----
   // access phase decode
   // ----
   logic acc;
   assign acc = apb_i.psel && apb_i.penable;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   reset_off_a: assert property ($fell(srst_i) |->
      !primary_switch_drive_o && !secondary_switch_drive_o) else $error("drive after reset");
   polarity_a: assert property (!SAME_POLARITY && primary_switch_drive_o |->
      !secondary_switch_drive_o) else $error("secondary not opposite");
   overload_a: assert property (input_monitor_high_i |=> !primary_switch_drive_o)
      else $error("drive kept on overload");
   // off time is at least four ticks, hence at least four clocks
   min_off_a: assert property ($fell(primary_switch_drive_o) |->
      !primary_switch_drive_o [*4]) else $error("off time too short");
   power_off_a: assert property (acc && apb_i.pwrite && apb_i.paddr == 32'h38 &&
      apb_i.pwdata[4] |-> ##2 (!primary_switch_drive_o && !secondary_switch_drive_o))
      else $error("drive after power off");
   bad_addr_a: assert property (acc && (apb_i.paddr[1:0] != 2'h0 ||
      apb_i.paddr[9:2] == 8'h40) |-> pslverr_o) else $error("no error on bad address");
   idle_err_a: assert property (!acc |-> !pslverr_o) else $error("error outside access");
   idle_rdata_a: assert property (!acc |-> prdata_o == 32'h0)
      else $error("read data outside access");

   cover property ($rose(primary_switch_drive_o));
   cover property (input_monitor_high_i && primary_switch_drive_o);
   cover property (pslverr_o);
endmodule

bind battery_dcdc_pwm_controller battery_dcdc_pwm_controller_sva #(
   .SAME_POLARITY(SAME_POLARITY)
) i_sva (
   .ref_clk_i(ref_clk_i),
   .srst_i(srst_i),
   .apb_i(apb_i),
   .prdata_o(prdata_o),
   .pslverr_o(pslverr_o),
   .input_monitor_high_i(input_monitor_high_i),
   .primary_switch_drive_o(primary_switch_drive_o),
   .secondary_switch_drive_o(secondary_switch_drive_o)
);

// ===== verification/dcdc_switch_stage_model.sv
// behavioural switching stage: output charges while switched, monitors on command
`timescale 1ns/1ps
module dcdc_switch_stage_model (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic switch_on_i,
   input wire logic overload_i,
   output logic [5:0] battery_sense_o,
   output logic input_monitor_high_o,
   output logic input_monitor_low_o
);
   // ----
   // slow charge, never leaks, so the loop sees a sluggish plant
   // ----
   logic [8:0] charge_q;
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         charge_q <= 9'h000;
      end else if (switch_on_i && charge_q != 9'h1ff) begin
         charge_q <= charge_q + 9'h001;
      end
   end
   assign battery_sense_o = charge_q[8:3];
   // both monitors trip together on an overload
   assign input_monitor_high_o = overload_i;
   assign input_monitor_low_o = overload_i;
endmodule

// ===== verification/battery_dcdc_pwm_controller_tb_top.sv
// self-checking bench for the battery dc-dc pwm controller
`timescale 1ns/1ps
module battery_dcdc_pwm_controller_tb_top import dcdc_pkg::*;;
   logic clk = 1'b0;
   logic srst = 1'b1;
   apb_req_type req = '0;
   line_state_type line = '{1'b0, 1'b0, 6'h30, 6'h0f, 6'h00};
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [5:0] sense;
   logic pready, pslverr, prim, sec, mon_h, mon_l, er;
   logic ovl = 1'b0;
   int num_errors = 0;
   int samples_checked = 0;

   // 20 MHz clock
   always #25 clk = ~clk;

   battery_dcdc_pwm_controller #(.SAME_POLARITY(1'b0), .CAL_CYCLES(8)) i_dut (
      .ref_clk_i(clk), .srst_i(srst), .apb_i(req), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .line_i(line), .battery_sense_i(sense),
      .input_monitor_high_i(mon_h), .input_monitor_low_i(mon_l),
      .primary_switch_drive_o(prim), .secondary_switch_drive_o(sec));
   dcdc_switch_stage_model i_stage (.ref_clk_i(clk), .srst_i(srst), .switch_on_i(prim),
      .overload_i(ovl), .battery_sense_o(sense), .input_monitor_high_o(mon_h),
      .input_monitor_low_o(mon_l));

   // ----
   // shared tasks
   // ----
   task automatic results();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // one apb transfer; request held until pready seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge clk);
      req <= {1'b1, 1'b0, wr, {22'h0, idx, 2'b00}, wd};
      @(posedge clk);
      req.penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         num_errors++;
         results();
      end
      rd = prdata;
      er = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string msg);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp, msg);
   endtask
   task automatic wait_prim(input logic lvl);
      int n;
      for (n = 0; n < 800; n++) begin
         @(negedge clk);
         if (prim === lvl) break;
      end
      if (n == 800) begin
         num_errors++;
         results();
      end
   endtask

   // ----
   // scenarios
   // ----
   task automatic t_reset();
      logic [7:0] ix [8] = '{8'h0e, 8'h42, 8'h4a, 8'h4b, 8'h5c, 8'h5d, 8'h5e, 8'h6c};
      logic [7:0] rv [8] = '{8'h10, 8'h04, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
      @(negedge clk);
      chk({30'h0, prim, sec}, 32'h0, "drives after reset");
      for (int i = 0; i < 8; i++) rdc(ix[i], {24'h0, rv[i]}, "reset value");
   endtask
   task automatic t_access();
      logic [7:0] ix [4] = '{8'h42, 8'h4a, 8'h4b, 8'h6c};
      logic [7:0] wv [4] = '{8'h05, 8'h2a, 8'h15, 8'h22};
      apb(1'b1, 8'h5e, 32'hff);
      rdc(8'h5e, 32'h0, "width is read only");
      apb(1'b1, 8'h5d, 32'h23);
      rdc(8'h5d, 32'h03, "polarity read only");
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped error");
      // high setting written above ringing swing
      for (int i = 0; i < 4; i++) apb(1'b1, ix[i], {24'h0, wv[i]});
      for (int i = 0; i < 4; i++) rdc(ix[i], {24'h0, wv[i]}, "rw readback");
      apb(1'b1, 8'h6c, 32'h0);
   endtask
   task automatic t_indirect();
      apb(1'b1, 8'h1e, 32'd41);
      apb(1'b1, 8'h1c, 32'h3);
      apb(1'b1, 8'h1e, 32'd41);
      rdc(8'h1c, 32'h3, "indirect headroom");
      rdc(8'h1d, 32'h0, "indirect high");
   endtask
   task automatic t_power();
      apb(1'b1, 8'h5c, 32'h08);
      apb(1'b1, 8'h5d, 32'h00);
      apb(1'b1, 8'h0e, 32'h00);
      apb(1'b1, 8'h5d, 32'h80);
      rdc(8'h5d, 32'h80, "calibration busy");
      repeat (20) @(posedge clk);
      rdc(8'h5d, 32'h00, "calibration done");
      for (int i = 0; i < 300; i++) begin
         @(negedge clk);
         chk({31'h0, sec}, {31'h0, ~prim}, "opposite polarity");
      end
      rdc(8'h5e, 32'h04, "width at period less off time");
      apb(1'b1, 8'h5d, 32'h02);
      repeat (100) @(posedge clk);
      rdc(8'h5e, 32'h02, "width at new cap");
   endtask
   task automatic t_ringing();
      apb(1'b1, 8'h4a, 32'h0);
      line.ringing <= 1'b1;
      repeat (200) @(posedge clk);
      rdc(8'h5e, 32'h0, "ringing follows high setting");
      line.ringing <= 1'b0;
      repeat (200) @(posedge clk);
      rdc(8'h5e, 32'h02, "active target again");
   endtask
   task automatic t_overload();
      apb(1'b1, 8'h5c, 32'h20);
      repeat (600) @(posedge clk);
      wait_prim(1'b0);
      wait_prim(1'b1);
      @(posedge clk);
      ovl <= 1'b1;
      repeat (2) @(posedge clk);
      ovl <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         chk({31'h0, prim}, 32'h0, "pulse cut for the period");
      end
   endtask
   task automatic t_off();
      apb(1'b1, 8'h0e, 32'h10);
      repeat (3) @(posedge clk);
      for (int i = 0; i < 100; i++) begin
         @(negedge clk);
         chk({30'h0, prim, sec}, 32'h0, "held off");
      end
   endtask

   // main sequence, reset held six cycles
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_access();
      t_indirect();
      t_power();
      t_ringing();
      t_overload();
      t_off();
      results();
   end
endmodule
